// ### cmb_buffer_ram.sv
// Purpose: buffer memory for 32 CAN messages, shared by the bus and the protocol engine.
// Assumes: AHB-Lite single word transfers; protocol engine runs on hclk.
// Notes: engine writes win over a bus write to the same word in the same cycle.
module cmb_buffer_ram import cmb_pkg::*; (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // protocol engine receive store
   input wire logic rx_valid,
   input wire logic [4:0] rx_buf,
   input wire cmb_msg_t rx_msg,
   // protocol engine transmit fetch
   input wire logic tx_req,
   input wire logic [4:0] tx_buf,
   output logic tx_valid,
   output cmb_msg_t tx_msg
);

   // buffer storage, deliberately without reset
   logic [15:0] mem_q [MEM_WORDS];

   // control and status state
   logic rx_en_q;
   logic tx_en_q;
   logic [4:0] last_rx_q;
   logic rx_seen_q;
   logic [CNT_W-1:0] rx_cnt_q;
   logic [CNT_W-1:0] tx_cnt_q;

   // bus data phase state
   logic dph_wr_q;
   cmb_tgt_t dph_tgt_q;
   logic [MEM_IDX_W-1:0] dph_idx_q;
   logic [1:0] dph_be_q;

   // output flops
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic hresp_q;
   logic tx_valid_q;
   cmb_msg_t tx_msg_q;

   // address phase decode
   logic ahb_take;
   logic a_is_mem;
   logic a_is_ctrl;
   logic a_is_stat;
   cmb_tgt_t a_tgt;
   logic [MEM_IDX_W-1:0] a_idx;
   logic [1:0] a_be;

   assign ahb_take = hsel & htrans[1] & hready;
   assign a_is_mem = haddr < MEM_LIMIT;
   assign a_is_ctrl = haddr[31:2] == CTRL_OFF[31:2];
   assign a_is_stat = haddr[31:2] == STAT_OFF[31:2];
   assign a_idx = haddr[MEM_IDX_W+1:2];

   always_comb begin
      if (!ahb_take) begin
         a_tgt = TGT_NONE;
      end else if (a_is_mem) begin
         a_tgt = TGT_MEM;
      end else if (a_is_ctrl) begin
         a_tgt = TGT_CTRL;
      end else if (a_is_stat) begin
         a_tgt = TGT_STAT;
      end else begin
         a_tgt = TGT_NONE;
      end
   end

   // byte lanes of the low halfword touched by this access
   always_comb begin
      if (hsize == 3'h0) begin
         a_be = {haddr[1:0] == 2'h1, haddr[1:0] == 2'h0};
      end else if (hsize == 3'h1) begin
         a_be = {~haddr[1], ~haddr[1]};
      end else begin
         a_be = 2'b11;
      end
   end

   // receive store from the engine
   logic rx_we;
   assign rx_we = rx_valid & rx_en_q;

   // bus write of one buffer word
   logic bus_we;
   logic [15:0] bus_old;
   logic [15:0] bus_new;
   assign bus_we = dph_wr_q & (dph_tgt_q == TGT_MEM);
   assign bus_old = mem_q[dph_idx_q];
   assign bus_new = {dph_be_q[1] ? hwdata[15:8] : bus_old[15:8],
                     dph_be_q[0] ? hwdata[7:0] : bus_old[7:0]} & word_mask(dph_idx_q[2:0]);

   // a bus write to the word the engine stores this cycle is dropped
   logic bus_lost;
   assign bus_lost = rx_we & (rx_buf == dph_idx_q[MEM_IDX_W-1:WORD_IDX_W]);

   always_ff @(posedge hclk) begin
      if (bus_we && !bus_lost) begin
         mem_q[dph_idx_q] <= bus_new;
      end
      if (rx_we) begin
         for (int w = 0; w < WORDS_PER_BUF; w++) begin
            mem_q[{rx_buf, w[WORD_IDX_W-1:0]}] <= pack_word(rx_msg, w[WORD_IDX_W-1:0]);
         end
      end
   end

   // read value of the addressed word, with same-cycle writes forwarded
   logic rd_rx_hit;
   logic rd_bus_hit;
   logic [15:0] rd_word;
   assign rd_rx_hit = rx_we & (rx_buf == a_idx[MEM_IDX_W-1:WORD_IDX_W]);
   assign rd_bus_hit = bus_we & ~bus_lost & (dph_idx_q == a_idx);

   always_comb begin
      if (rd_rx_hit) begin
         rd_word = pack_word(rx_msg, a_idx[WORD_IDX_W-1:0]);
      end else if (rd_bus_hit) begin
         rd_word = bus_new;
      end else begin
         rd_word = mem_q[a_idx];
      end
   end

   // register view
   logic [31:0] ctrl_view;
   logic [31:0] stat_view;
   always_comb begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[CTRL_RX_EN_BIT] = rx_en_q;
      ctrl_view[CTRL_TX_EN_BIT] = tx_en_q;
      stat_view = 32'h0000_0000;
      stat_view[STAT_LAST_LSB +: 5] = last_rx_q;
      stat_view[STAT_RX_SEEN_BIT] = rx_seen_q;
      stat_view[STAT_RXCNT_LSB +: CNT_W] = rx_cnt_q;
      stat_view[STAT_TXCNT_LSB +: CNT_W] = tx_cnt_q;
   end

   logic [31:0] rd_value;
   always_comb begin
      if (a_tgt == TGT_MEM) begin
         rd_value = {16'h0000, rd_word};
      end else if (a_tgt == TGT_CTRL) begin
         rd_value = ctrl_view;
      end else if (a_tgt == TGT_STAT) begin
         rd_value = stat_view;
      end else begin
         rd_value = 32'h0000_0000;
      end
   end

   // bus pipeline: read data is ready in the data phase, writes commit at its end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_q <= 1'b0;
         dph_tgt_q <= TGT_NONE;
         dph_idx_q <= '0;
         dph_be_q <= 2'b00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         dph_wr_q <= ahb_take & hwrite;
         dph_tgt_q <= a_tgt;
         dph_idx_q <= a_idx;
         dph_be_q <= a_be;
         hrdata_q <= (ahb_take && !hwrite) ? rd_value : 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // control register: enables for the engine ports
   logic ctrl_we;
   assign ctrl_we = dph_wr_q & (dph_tgt_q == TGT_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_en_q <= CTRL_RESET[CTRL_RX_EN_BIT];
         tx_en_q <= CTRL_RESET[CTRL_TX_EN_BIT];
      end else if (ctrl_we && dph_be_q[0]) begin
         rx_en_q <= hwdata[CTRL_RX_EN_BIT];
         tx_en_q <= hwdata[CTRL_TX_EN_BIT];
      end
   end

   // status: last receive buffer, receive seen flag and receive counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_rx_q <= 5'h00;
         rx_seen_q <= 1'b0;
         rx_cnt_q <= '0;
      end else if (rx_we) begin
         last_rx_q <= rx_buf;
         rx_seen_q <= 1'b1;
         rx_cnt_q <= rx_cnt_q + 8'h01;
      end
   end

   // transmit fetch: gather the eight words of the chosen buffer
   logic tx_take;
   logic [7:0][15:0] tx_words;
   cmb_msg_t tx_decoded;
   cmb_msg_t tx_clean;
   assign tx_take = tx_req & tx_en_q;

   for (genvar g = 0; g < WORDS_PER_BUF; g++) begin : g_tx_words
      assign tx_words[g] = mem_q[{tx_buf, 3'(g)}];
   end

   cmb_msg_unpack u_unpack (
      .words(tx_words),
      .msg(tx_decoded)
   );

   always_comb begin
      tx_clean = tx_decoded;
      tx_clean.filter_hit = 5'h00;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_valid_q <= 1'b0;
         tx_msg_q <= '0;
         tx_cnt_q <= '0;
      end else begin
         tx_valid_q <= tx_take;
         if (tx_take) begin
            tx_msg_q <= tx_clean;
            tx_cnt_q <= tx_cnt_q + 8'h01;
         end
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;
   assign tx_valid = tx_valid_q;
   assign tx_msg = tx_msg_q;

endmodule // cmb_buffer_ram

// ### cmb_buffer_ram_assertions.sv
// Purpose: port-level checks of the message buffer memory.
// Assumes: one slave, hready tied to hreadyout.
// Notes: read data phase is tracked by a small flag.
module cmb_buffer_ram_chk import cmb_pkg::*; (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // engine
   input wire logic rx_valid,
   input wire logic [4:0] rx_buf,
   input wire cmb_msg_t rx_msg,
   input wire logic tx_req,
   input wire logic [4:0] tx_buf,
   input wire logic tx_valid,
   input wire cmb_msg_t tx_msg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_q;
   logic mem_q;
   logic [2:0] w_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         mem_q <= 1'b0;
         w_q <= 3'h0;
      end else begin
         rd_q <= hsel && htrans[1] && hready && !hwrite;
         mem_q <= haddr < MEM_LIMIT;
         w_q <= haddr[4:2];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rx_then_tx;
      rx_valid ##1 (tx_req && tx_buf == $past(rx_buf));
   endsequence
   property store_fetch_p;
      rx_then_tx |=> tx_valid && tx_msg.ext_id == $past(rx_msg.ext_id, 2) && tx_msg.data == $past(rx_msg.data, 2);
   endproperty
   okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bad bus response");
   idle_rdata_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside read");
   sid_unused_a: assert property (rd_q && mem_q && w_q == W_SID |-> hrdata[31:13] == 19'h0)
      else $error("sid unused bits set");
   eid_unused_a: assert property (rd_q && mem_q && w_q == W_EID |-> hrdata[31:12] == 20'h0)
      else $error("eid unused bits set");
   dlc_unused_a: assert property (rd_q && mem_q && w_q == W_DLC |-> hrdata[31:16] == 16'h0 && hrdata[7:5] == 3'h0)
      else $error("length word unused bits set");
   stat_unused_a: assert property (rd_q && mem_q && w_q == W_STAT |-> hrdata[31:13] == 19'h0 && hrdata[7:0] == 8'h0)
      else $error("status unused bits set");
   fetch_answer_a: assert property (tx_valid |-> $past(tx_req)) else $error("fetch answer without request");
   tx_hit_zero_a: assert property (tx_valid |-> tx_msg.filter_hit == 5'h00) else $error("hit code on fetch");
   store_fetch_a: assert property (store_fetch_p) else $error("fetch differs from store");
endmodule // cmb_buffer_ram_chk

bind cmb_buffer_ram cmb_buffer_ram_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
   .hrdata, .hresp, .rx_valid, .rx_buf, .rx_msg, .tx_req, .tx_buf, .tx_valid, .tx_msg);

// ### cmb_buffer_ram_tb.sv
// Purpose: self-checking bench for the message buffer memory.
// Assumes: ahb-lite master without pipelining; engine model on the far side.
// Notes: buffer n starts at byte n*32.
module cmb_buffer_ram_tb;
   import cmb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   wire logic hreadyout, hresp, rx_valid, tx_req, tx_valid;
   wire logic [31:0] hrdata;
   wire logic [4:0] rx_buf, tx_buf;
   wire cmb_msg_t rx_msg, tx_msg;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   cmb_buffer_ram uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .rx_valid(rx_valid), .rx_buf(rx_buf), .rx_msg(rx_msg), .tx_req(tx_req), .tx_buf(tx_buf), .tx_valid(tx_valid),
      .tx_msg(tx_msg));
   cmb_engine_model eng (.hclk(hclk), .rx_valid(rx_valid), .rx_buf(rx_buf), .rx_msg(rx_msg), .tx_req(tx_req),
      .tx_buf(tx_buf), .tx_valid(tx_valid), .tx_msg(tx_msg));
   initial forever #4 hclk = ~hclk;
   task automatic complete_run();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   // all-ones into buffer 31 but 32'hFFFF_FEEF into the length word, which keeps the reserved bits clear
   task automatic t_masks();
      logic [15:0] exp [8] = '{16'h1FFF, 16'h0FFF, 16'hFE0F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1F00};
      logic [31:0] r;
      for (int w = 0; w < 8; w++) begin
         ahb(1'b1, 32'h3E0 + w * 4, (w == 2) ? 32'hFFFF_FEEF : 32'hFFFF_FFFF, r);
         ahb(1'b0, 32'h3E0 + w * 4, 32'h0, r);
         check("masked word", r, {16'h0, exp[w]});
      end
      ahb(1'b0, 32'h800, 32'h0, r);
      check("unmapped read", r, 32'h0);
   endtask
   // engine stores into buffers 0 and 31, then fetches each back at once
   task automatic t_store();
      cmb_msg_t m, e, got;
      logic [15:0] exp [8];
      logic [31:0] r;
      int n;
      m = '0;
      m.std_id = 11'h5A3;
      m.srr = 1'b1;
      m.ide = 1'b1;
      m.ext_id = 18'h2B4C7;
      m.rtr = 1'b1;
      m.dlc = 4'h8;
      m.data = 64'h8877_6655_4433_2211;
      exp = '{16'h168F, 16'h0AD3, 16'h1E08, 16'h2211, 16'h4433, 16'h6655, 16'h8877, 16'h0000};
      for (int k = 0; k < 2; k++) begin
         m.filter_hit = k ? 5'h1F : 5'h00;
         exp[7] = {3'h0, m.filter_hit, 8'h00};
         eng.store(k ? 5'h1F : 5'h00, m);
         eng.fetch(k ? 5'h1F : 5'h00, got, n);
         e = m;
         e.filter_hit = 5'h00;
         check("fetch latency", n, 1);
         check("fetched message", got, e);
         for (int w = 0; w < 8; w++) begin
            ahb(1'b0, k * 32'h3E0 + w * 4, 32'h0, r);
            check("stored word", r, {16'h0, exp[w]});
         end
      end
   endtask
   // software builds buffer 9, engine fetches it
   task automatic t_bus_tx();
      logic [15:0] wd [8] = '{16'h0006, 16'h0FFF, 16'hAA04, 16'hB2A1, 16'hD4C3, 16'hF6E5, 16'h1807, 16'h1F00};
      cmb_msg_t e, got;
      logic [31:0] r;
      int n;
      for (int w = 0; w < 8; w++) ahb(1'b1, 32'h120 + w * 4, {16'h0, wd[w]}, r);
      eng.fetch(5'h09, got, n);
      e = '0;
      e.std_id = 11'h001;
      e.srr = 1'b1;
      e.ext_id = {12'hFFF, 6'h2A};
      e.rtr = 1'b1;
      e.dlc = 4'h4;
      e.data = 64'h1807_F6E5_D4C3_B2A1;
      check("fetch latency", n, 1);
      check("bus built message", got, e);
   endtask
   // enables off refuse store and fetch; a second reset restores them but keeps the buffers
   task automatic t_ctrl();
      cmb_msg_t m, got;
      logic [31:0] r;
      int n;
      ahb(1'b0, CTRL_OFF, 32'h0, r);
      check("control after reset", r, CTRL_RESET);
      check("okay response", hresp, 1'b0);
      ahb(1'b0, STAT_OFF, 32'h0, r);
      check("status counts", r, 32'h0302_011F);
      ahb(1'b1, CTRL_OFF, 32'h0, r);
      m = '0;
      m.std_id = 11'h7FF;
      eng.store(5'h09, m);
      ahb(1'b0, 32'h120, 32'h0, r);
      check("refused store", r, 32'h0000_0006);
      eng.fetch(5'h09, got, n);
      check("refused fetch", n, 4);
      ahb(1'b0, STAT_OFF, 32'h0, r);
      check("status when refused", r, 32'h0302_011F);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, CTRL_OFF, 32'h0, r);
      check("control after second reset", r, CTRL_RESET);
      ahb(1'b0, STAT_OFF, 32'h0, r);
      check("status after second reset", r, 32'h0000_0000);
      ahb(1'b0, 32'h120, 32'h0, r);
      check("buffer kept over reset", r, 32'h0000_0006);
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_masks();
      t_store();
      t_bus_tx();
      t_ctrl();
      complete_run();
   end
endmodule // cmb_buffer_ram_tb

// ### cmb_engine_model.sv
// Purpose: protocol engine stand-in that stores and fetches whole messages.
// Assumes: engine runs on hclk; requests change just after a rising edge.
// Notes: released lines show the inverse of the last value.
module cmb_engine_model import cmb_pkg::*; (
   // clock
   input wire logic hclk,
   // store side
   output logic rx_valid,
   output logic [4:0] rx_buf,
   output cmb_msg_t rx_msg,
   // fetch side
   output logic tx_req,
   output logic [4:0] tx_buf,
   input wire logic tx_valid,
   input wire cmb_msg_t tx_msg
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_valid = 1'b0;
      rx_buf = 5'h00;
      rx_msg = '0;
      tx_req = 1'b0;
      tx_buf = 5'h00;
   end
   task automatic store(input logic [4:0] b, input cmb_msg_t m);
      rx_valid <= 1'b1;
      rx_buf <= b;
      rx_msg <= m;
      @(posedge hclk);
      rx_valid <= 1'b0;
      rx_buf <= ~b;
      rx_msg <= ~m;
   endtask
   // n counts edges from the taken edge to the one that sees the answer
   task automatic fetch(input logic [4:0] b, output cmb_msg_t m, output int n);
      logic ok;
      tx_req <= 1'b1;
      tx_buf <= b;
      @(posedge hclk);
      tx_req <= 1'b0;
      tx_buf <= ~b;
      ok = 1'b0;
      n = 0;
      m = '0;
      while (!ok && n < 4) begin
         @(posedge hclk);
         n++;
         if (tx_valid === 1'b1) begin
            ok = 1'b1;
            m = tx_msg;
         end
      end
   endtask
endmodule // cmb_engine_model

// ### cmb_pkg.sv
// Purpose: constants, types and word layout of the 32 CAN message buffers, plus the word unpacker.
// Assumes: one 16-bit buffer word per 32-bit bus word; data in bits 15:0, upper bits read as zero.
// Notes: buffer words are not reset; their contents are unknown until written.
package cmb_pkg;
   localparam int NUM_BUF = 32;
   localparam int BUF_IDX_W = 5;
   localparam int WORDS_PER_BUF = 8;
   localparam int WORD_IDX_W = 3;
   localparam int MEM_IDX_W = 8;
   localparam int MEM_WORDS = 256;
   localparam int CNT_W = 8;

   // word order inside one buffer
   localparam logic [2:0] W_SID = 3'h0;
   localparam logic [2:0] W_EID = 3'h1;
   localparam logic [2:0] W_DLC = 3'h2;
   localparam logic [2:0] W_D01 = 3'h3;
   localparam logic [2:0] W_D23 = 3'h4;
   localparam logic [2:0] W_D45 = 3'h5;
   localparam logic [2:0] W_D67 = 3'h6;
   localparam logic [2:0] W_STAT = 3'h7;

   // implemented bits of each word
   localparam logic [15:0] MASK_SID = 16'h1FFF;
   localparam logic [15:0] MASK_EID = 16'h0FFF;
   localparam logic [15:0] MASK_DLC = 16'hFF1F;
   localparam logic [15:0] MASK_DATA = 16'hFFFF;
   localparam logic [15:0] MASK_STAT = 16'h1F00;

   // bus map
   localparam logic [31:0] MEM_LIMIT = 32'h0000_0400;
   localparam logic [31:0] CTRL_OFF = 32'h0000_0400;
   localparam logic [31:0] STAT_OFF = 32'h0000_0404;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
   localparam int CTRL_RX_EN_BIT = 0;
   localparam int CTRL_TX_EN_BIT = 1;
   localparam int STAT_LAST_LSB = 0;
   localparam int STAT_RX_SEEN_BIT = 8;
   localparam int STAT_RXCNT_LSB = 16;
   localparam int STAT_TXCNT_LSB = 24;

   typedef enum logic [1:0] {
      TGT_NONE = 2'b00,
      TGT_MEM = 2'b01,
      TGT_CTRL = 2'b10,
      TGT_STAT = 2'b11
   } cmb_tgt_t;

   typedef struct packed {
      logic [10:0] std_id;
      logic srr;
      logic ide;
      logic [17:0] ext_id;
      logic rtr;
      logic rb1;
      logic rb0;
      logic [3:0] dlc;
      logic [7:0][7:0] data;
      logic [4:0] filter_hit;
   } cmb_msg_t;

   function automatic logic [15:0] word_mask(input logic [2:0] w);
      logic [15:0] m;
      m = MASK_DATA;
      if (w == W_SID) begin
         m = MASK_SID;
      end else if (w == W_EID) begin
         m = MASK_EID;
      end else if (w == W_DLC) begin
         m = MASK_DLC;
      end else if (w == W_STAT) begin
         m = MASK_STAT;
      end
      return m;
   endfunction

   function automatic logic [15:0] pack_word(input cmb_msg_t msg, input logic [2:0] w);
      logic [15:0] r;
      r = 16'h0000;
      case (w)
         W_SID: r = {3'h0, msg.std_id, msg.srr, msg.ide};
         W_EID: r = {4'h0, msg.ext_id[17:6]};
         W_DLC: r = {msg.ext_id[5:0], msg.rtr, msg.rb1, 3'h0, msg.rb0, msg.dlc};
         W_D01: r = {msg.data[1], msg.data[0]};
         W_D23: r = {msg.data[3], msg.data[2]};
         W_D45: r = {msg.data[5], msg.data[4]};
         W_D67: r = {msg.data[7], msg.data[6]};
         default: r = {3'h0, msg.filter_hit, 8'h00};
      endcase
      return r & word_mask(w);
   endfunction
endpackage

// rebuilds a message from the eight words of one buffer
module cmb_msg_unpack import cmb_pkg::*; (
   // buffer words in order
   input wire logic [7:0][15:0] words,
   // decoded message
   output cmb_msg_t msg
);
   assign msg.std_id = words[W_SID][12:2];
   assign msg.srr = words[W_SID][1];
   assign msg.ide = words[W_SID][0];
   assign msg.ext_id = {words[W_EID][11:0], words[W_DLC][15:10]};
   assign msg.rtr = words[W_DLC][9];
   assign msg.rb1 = words[W_DLC][8];
   assign msg.rb0 = words[W_DLC][4];
   assign msg.dlc = words[W_DLC][3:0];
   assign msg.data = {words[W_D67], words[W_D45], words[W_D23], words[W_D01]};
   assign msg.filter_hit = words[W_STAT][12:8];
endmodule // cmb_msg_unpack
